// [verilog/chan_sched_pkg.sv]
// package: shared constants and carrier types for the channel service scheduler
package chan_sched_pkg;

    localparam int          NUM_CHAN      = 16;
    localparam int          CHAN_W        = 4;
    localparam int          SLOTS_PER_SEQ = 7;
    localparam int          CLK_MHZ       = 125;

    // priority level encodings
    localparam logic [1:0]  PRIO_OFF      = 2'h0;
    localparam logic [1:0]  PRIO_LOW      = 2'h1;
    localparam logic [1:0]  PRIO_MID      = 2'h2;
    localparam logic [1:0]  PRIO_HIGH     = 2'h3;

    // fixed slot sequence H-M-H-L-H-M-H, index 0 first
    localparam logic [13:0] SLOT_SEQ      = {PRIO_HIGH, PRIO_MID, PRIO_HIGH, PRIO_LOW,
                                             PRIO_HIGH, PRIO_MID, PRIO_HIGH};

    // timing, counted in cpu clocks
    localparam logic [3:0]  XFER_CLKS     = 4'hA;   // slot transition
    localparam logic [3:0]  NOP_CLKS      = 4'h4;   // group-clear no-op
    localparam logic [1:0]  RAM_STALL_MAX = 2'h2;   // parameter memory loser stall

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_NOP   = 2'b11,
        ST_XFER  = 2'b10
    } sched_state_e;

    // grant towards the execution unit
    typedef struct packed {
        logic              valid;
        logic [CHAN_W-1:0] chan;
        logic [1:0]        level;
    } grant_s;

    // parameter memory arbitration result
    typedef struct packed {
        logic exec_gnt;
        logic host_gnt;
        logic exec_stall;
        logic host_stall;
    } ram_arb_s;

endpackage

// [verilog/param_ram_arb.sv]
// parameter memory arbiter between execution unit and host processor
`timescale 1ns/10ps
module param_ram_arb (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rstn,
    input  wire logic                 i_exec_req,
    input  wire logic                 i_host_req,
    output chan_sched_pkg::ram_arb_s  o_arb
);

    typedef struct packed {
        logic       owner_host;   // 1: host wins the memory if both request this cycle
        logic [1:0] stall_cnt;
    } arb_state_s;

    arb_state_s state_reg;
    arb_state_s state_next;

    // one access per clock; on contention the owner keeps the memory two clocks, then ownership flips, so no stall exceeds two clocks
    always_comb begin
        state_next      = state_reg;
        if (i_exec_req && i_host_req) begin
            if (state_reg.stall_cnt >= chan_sched_pkg::RAM_STALL_MAX - 2'h1) begin
                state_next.owner_host = ~state_reg.owner_host;
                state_next.stall_cnt  = 2'h0;
            end else begin
                state_next.stall_cnt = state_reg.stall_cnt + 2'h1;
            end
        end else begin
            state_next.owner_host = i_host_req;
            state_next.stall_cnt  = 2'h0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // grants are handshakes and may be combinational; never both at once
    always_comb begin
        o_arb.host_gnt   = i_host_req & (~i_exec_req | state_reg.owner_host);
        o_arb.exec_gnt   = i_exec_req & ~o_arb.host_gnt;
        o_arb.exec_stall = i_exec_req & ~o_arb.exec_gnt;
        o_arb.host_stall = i_host_req & ~o_arb.host_gnt;
    end

    a_ram_exclusive: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        !(o_arb.exec_gnt && o_arb.host_gnt))
        else $error("both parties granted the parameter memory");

    a_ram_stall_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_arb.exec_stall [*3] |-> 1'b0)
        else $error("execution unit stalled longer than two clocks");

    a_ram_host_bound: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_arb.host_stall [*3] |-> 1'b0)
        else $error("host stalled longer than two clocks");

endmodule

// [verilog/channel_service_scheduler.sv]
// channel service scheduler: slot sequencing, priority passing and per-channel latches
`timescale 1ns/10ps

// Function
// - slots follow fixed order H,M,H,L,H,M,H: four high, two middle, one low
// - one function state runs per slot; slot length follows the state's own length
// - after slot seven a new sequence starts at slot one with no gap
// - each channel has high, middle or low priority; grant uses priority and number; a channel at PRIO_OFF is never granted
// - empty high slot passes to middle, else to low
// - empty middle slot passes to high, else to low
// - empty low slot passes to high, else to middle
// - with no request at all the scheduler waits on the current slot
// - priority passing is combinational and adds no clocks
// - ten clocks of preparation between the end of one slot and the next
// - among eligible channels of one level the lowest number wins
// - a just-served channel waits until its level's other requesters are served
// - request latch set by request; on grant grant latch set, request latch cleared
// - grant latches clear only as a whole level, which starts a new cycle
// - after service, clear the level's grant latches if none eligible remains
// - each group clear inserts a four-clock no-operation delay
// - parameter memory admits one party at a time; the loser stalls up to two clocks
// - sixteen channels share a single execution unit
module channel_service_scheduler (
    input  wire logic                                          i_ref_clk,
    input  wire logic                                          i_rstn,
    input  wire logic [chan_sched_pkg::NUM_CHAN-1:0]           i_chan_req,
    input  wire logic [chan_sched_pkg::NUM_CHAN-1:0][1:0]      i_chan_prio,
    input  wire logic                                          i_state_done,
    input  wire logic                                          i_exec_ram_req,
    input  wire logic                                          i_host_ram_req,
    output chan_sched_pkg::grant_s                             o_grant,
    output logic                                               o_exec_start,
    output logic [2:0]                                         o_slot_idx,
    output logic [1:0]                                         o_slot_level,
    output logic                                               o_nop_busy,
    output logic                                               o_xfer_busy,
    output logic [chan_sched_pkg::NUM_CHAN-1:0]                o_service_request_latch,
    output logic [chan_sched_pkg::NUM_CHAN-1:0]                o_service_grant_latch,
    output chan_sched_pkg::ram_arb_s                           o_ram_arb
);

    localparam int N = chan_sched_pkg::NUM_CHAN;

    typedef struct packed {
        chan_sched_pkg::sched_state_e       st;
        logic [2:0]                         slot;
        logic [N-1:0]                       req_latch;
        logic [N-1:0]                       gnt_latch;
        logic [3:0]                         cnt;
        logic                               grp_clear;   // unused; never set, the group clear runs through ST_NOP
        chan_sched_pkg::grant_s             grant;
        logic                               start;
    } sched_s;

    sched_s s_reg;
    sched_s s_next;

    //------------------------------------------------------------
    // decoding helpers
    //------------------------------------------------------------

    // level assigned to a slot position of the fixed sequence
    function automatic logic [1:0] slot_level(input logic [2:0] idx);
        logic [1:0] lvl;
        lvl = chan_sched_pkg::PRIO_HIGH;
        if (idx < 3'h7) begin
            lvl = chan_sched_pkg::SLOT_SEQ[idx*2 +: 2];
        end
        return lvl;
    endfunction

    // lowest numbered set bit; ties broken by channel number
    function automatic logic [chan_sched_pkg::CHAN_W-1:0] lowest_set(input logic [N-1:0] v);
        logic [chan_sched_pkg::CHAN_W-1:0] idx;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[chan_sched_pkg::CHAN_W-1:0];
            end
        end
        return idx;
    endfunction

    //------------------------------------------------------------
    // eligibility per level
    //------------------------------------------------------------

    logic [N-1:0] elig_high;
    logic [N-1:0] elig_mid;
    logic [N-1:0] elig_low;
    logic [N-1:0] req_seen;

    // a channel posting a request this cycle counts at once, so no clock is lost to latching
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_elig
            assign req_seen[g]  = s_reg.req_latch[g] | i_chan_req[g];
            assign elig_high[g] = req_seen[g] & ~s_reg.gnt_latch[g]
                                  & (i_chan_prio[g] == chan_sched_pkg::PRIO_HIGH);
            assign elig_mid[g]  = req_seen[g] & ~s_reg.gnt_latch[g]
                                  & (i_chan_prio[g] == chan_sched_pkg::PRIO_MID);
            assign elig_low[g]  = req_seen[g] & ~s_reg.gnt_latch[g]
                                  & (i_chan_prio[g] == chan_sched_pkg::PRIO_LOW);
        end
    endgenerate

    //------------------------------------------------------------
    // priority passing, purely combinational
    //------------------------------------------------------------

    logic [1:0]   cur_level;
    logic [1:0]   pick_level;
    logic [N-1:0] pick_vec;
    logic         any_elig;

    // passing order per slot level costs no cycle since it is decided in the same clock
    always_comb begin
        cur_level  = slot_level(s_reg.slot);
        any_elig   = |{elig_high, elig_mid, elig_low};
        pick_level = chan_sched_pkg::PRIO_OFF;
        pick_vec   = '0;
        case (cur_level)
            chan_sched_pkg::PRIO_HIGH: begin
                if (|elig_high) begin
                    pick_level = chan_sched_pkg::PRIO_HIGH;
                end else if (|elig_mid) begin
                    pick_level = chan_sched_pkg::PRIO_MID;
                end else if (|elig_low) begin
                    pick_level = chan_sched_pkg::PRIO_LOW;
                end
            end
            chan_sched_pkg::PRIO_MID: begin
                if (|elig_mid) begin
                    pick_level = chan_sched_pkg::PRIO_MID;
                end else if (|elig_high) begin
                    pick_level = chan_sched_pkg::PRIO_HIGH;
                end else if (|elig_low) begin
                    pick_level = chan_sched_pkg::PRIO_LOW;
                end
            end
            chan_sched_pkg::PRIO_LOW: begin
                if (|elig_low) begin
                    pick_level = chan_sched_pkg::PRIO_LOW;
                end else if (|elig_high) begin
                    pick_level = chan_sched_pkg::PRIO_HIGH;
                end else if (|elig_mid) begin
                    pick_level = chan_sched_pkg::PRIO_MID;
                end
            end
            default: begin
                pick_level = chan_sched_pkg::PRIO_OFF;
            end
        endcase
        case (pick_level)
            chan_sched_pkg::PRIO_HIGH: pick_vec = elig_high;
            chan_sched_pkg::PRIO_MID:  pick_vec = elig_mid;
            chan_sched_pkg::PRIO_LOW:  pick_vec = elig_low;
            default:                   pick_vec = '0;
        endcase
    end

    //------------------------------------------------------------
    // group clear decision after service
    //------------------------------------------------------------

    logic [N-1:0] level_mask;
    logic         level_empty;

    // level members of the served channel; still-eligible member keeps the cycle open
    always_comb begin
        for (int i = 0; i < N; i++) begin
            level_mask[i] = (i_chan_prio[i] == s_reg.grant.level);
        end
        // the served channel's own grant latch is already set, so it never keeps its level open
        level_empty = ~|(level_mask & req_seen & ~s_reg.gnt_latch);
    end

    //------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------

    // one state per slot, then optional no-op, then transition, then next slot
    always_comb begin
        s_next       = s_reg;
        s_next.start = 1'b0;
        // new requests land in the latch, except a lone pulse on the channel granted in the same cycle
        s_next.req_latch = s_reg.req_latch | i_chan_req;
        case (s_reg.st)
            chan_sched_pkg::ST_IDLE: begin
                if (any_elig) begin
                    s_next.st          = chan_sched_pkg::ST_EXEC;
                    s_next.start       = 1'b1;
                    s_next.grant.valid = 1'b1;
                    s_next.grant.chan  = lowest_set(pick_vec);
                    s_next.grant.level = pick_level;
                    s_next.gnt_latch[lowest_set(pick_vec)] = 1'b1;
                    // a pulse that alone won this grant is consumed; only a latched one plus a new pulse stays
                    s_next.req_latch[lowest_set(pick_vec)] = s_reg.req_latch[lowest_set(pick_vec)]
                                                             & i_chan_req[lowest_set(pick_vec)];
                end
                // with nothing to serve the slot pointer stays put
            end
            chan_sched_pkg::ST_EXEC: begin
                if (i_state_done) begin
                    s_next.grant.valid = 1'b0;
                    if (level_empty) begin
                        // whole level cleared together, opening a new cycle
                        for (int i = 0; i < N; i++) begin
                            if (level_mask[i]) begin
                                s_next.gnt_latch[i] = 1'b0;
                            end
                        end
                        s_next.st  = chan_sched_pkg::ST_NOP;
                        s_next.cnt = chan_sched_pkg::NOP_CLKS - 4'h1;
                    end else begin
                        s_next.st  = chan_sched_pkg::ST_XFER;
                        s_next.cnt = chan_sched_pkg::XFER_CLKS - 4'h1;
                    end
                end
            end
            chan_sched_pkg::ST_NOP: begin
                if (s_reg.cnt == 4'h0) begin
                    s_next.st  = chan_sched_pkg::ST_XFER;
                    s_next.cnt = chan_sched_pkg::XFER_CLKS - 4'h1;
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            chan_sched_pkg::ST_XFER: begin
                if (s_reg.cnt == 4'h0) begin
                    s_next.st = chan_sched_pkg::ST_IDLE;
                    // wrap straight into a fresh sequence
                    if (s_reg.slot == 3'(chan_sched_pkg::SLOTS_PER_SEQ - 1)) begin
                        s_next.slot = 3'h0;
                    end else begin
                        s_next.slot = s_reg.slot + 3'h1;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 4'h1;
                end
            end
            default: begin
                s_next.st = chan_sched_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    //------------------------------------------------------------
    // parameter memory arbitration and outputs
    //------------------------------------------------------------

    // one shared unit serves all sixteen channels, the memory likewise has one port
    param_ram_arb u_ram_arb (
        .i_ref_clk  (i_ref_clk),
        .i_rstn     (i_rstn),
        .i_exec_req (i_exec_ram_req),
        .i_host_req (i_host_ram_req),
        .o_arb      (o_ram_arb)
    );

    assign o_grant                 = s_reg.grant;
    assign o_exec_start            = s_reg.start;
    assign o_slot_idx              = s_reg.slot;
    assign o_slot_level            = slot_level(s_reg.slot);
    assign o_nop_busy              = (s_reg.st == chan_sched_pkg::ST_NOP);
    assign o_xfer_busy             = (s_reg.st == chan_sched_pkg::ST_XFER);
    assign o_service_request_latch = s_reg.req_latch;
    assign o_service_grant_latch   = s_reg.gnt_latch;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------

    // reset aborts any attempt in flight, so a reset held two clocks or more never reads as a bad slot step
    sequence seq_done_keep;
        (s_reg.st == chan_sched_pkg::ST_EXEC) && i_state_done && !level_empty;
    endsequence

    sequence seq_xfer_ten;
        o_xfer_busy [*8] ##1 o_xfer_busy [*2] ##1 !o_xfer_busy;
    endsequence

    a_xfer_ten_clocks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        seq_done_keep |=> seq_xfer_ten)
        else $error("slot transition is not ten clocks");

    a_nop_four_clocks: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(o_nop_busy) |-> o_nop_busy [*4] ##1 o_xfer_busy)
        else $error("group clear no-op is not four clocks");

    a_slot_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (o_slot_idx == 3'h6) ##1 (o_slot_idx != 3'h6) |-> (o_slot_idx == 3'h0))
        else $error("sequence did not restart at slot one");

    a_slot_step: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $changed(o_slot_idx) |-> $past(o_xfer_busy) && !o_xfer_busy)
        else $error("slot advanced outside the end of a transition");

    a_idle_waits: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (s_reg.st == chan_sched_pkg::ST_IDLE) && !any_elig |=> $stable(o_slot_idx))
        else $error("slot moved with no request pending");

    a_pass_same_clock: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (s_reg.st == chan_sched_pkg::ST_IDLE) && any_elig |=> o_exec_start && o_grant.valid)
        else $error("grant did not follow a pending request by one clock");

    a_high_slot_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (s_reg.st == chan_sched_pkg::ST_IDLE) && (cur_level == chan_sched_pkg::PRIO_HIGH)
        && !(|elig_high) && (|elig_mid) |=> o_grant.level == chan_sched_pkg::PRIO_MID)
        else $error("empty high slot not passed to middle");

    a_low_slot_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (s_reg.st == chan_sched_pkg::ST_IDLE) && (cur_level == chan_sched_pkg::PRIO_LOW)
        && !(|elig_low) && (|elig_high) |=> o_grant.level == chan_sched_pkg::PRIO_HIGH)
        else $error("empty low slot not passed to high");

    a_grant_latch_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_exec_start |-> o_service_grant_latch[o_grant.chan])
        else $error("granted channel has no grant latch");

    a_no_repeat: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        o_exec_start |-> ($past(o_service_grant_latch) & (16'h1 << o_grant.chan)) == 16'h0)
        else $error("served channel picked again inside its cycle");

    a_mid_slot_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        (s_reg.st == chan_sched_pkg::ST_IDLE) && (cur_level == chan_sched_pkg::PRIO_MID)
        && !(|elig_mid) && (|elig_high) |=> o_grant.level == chan_sched_pkg::PRIO_HIGH)
        else $error("empty middle slot not passed to high");

    a_group_clear_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
        $past(i_rstn) && |($past(o_service_grant_latch) & ~o_service_grant_latch) |-> o_nop_busy)
        else $error("grant latch cleared outside a group clear");

endmodule

// [testbench/exec_unit_model.sv]
// behavioural execution unit that answers each grant with one state of random length
`timescale 1ns/10ps
module exec_unit_model (
    input  wire logic i_ref_clk,
    input  wire logic i_rstn,
    input  wire logic i_exec_start,
    input  wire logic i_exec_stall,
    output logic      o_state_done = 1'b0,
    output logic      o_ram_req    = 1'b0
);
    int cnt = 0;
    // ----------------
    // state execution
    // ----------------
    // a stalled memory access stretches the state, so slot length varies
    always @(posedge i_ref_clk) begin
        o_state_done <= 1'b0;
        if (!i_rstn) begin
            cnt <= 0;
            o_ram_req <= 1'b0;
        end else if (i_exec_start) begin
            cnt <= 3 + $urandom % 8;
            o_ram_req <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= i_exec_stall ? cnt : cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_state_done <= 1'b1;
            o_ram_req <= 1'b0;
        end
    end
endmodule

// [testbench/testbench.sv]
// self-checking bench for the channel service scheduler
`timescale 1ns/10ps
module testbench;
    logic                     clk = 1'b0, rstn = 1'b0, host = 1'b0, done, eram, start, nop, xfer;
    logic [15:0]              req = 16'h0, service_request_latch, service_grant_latch, srl_o, sgl_o;
    logic [15:0][1:0]         prio = '0;
    logic [2:0]               sidx;
    logic [1:0]               slv;
    chan_sched_pkg::grant_s   gnt;
    chan_sched_pkg::ram_arb_s arb;
    int                       slot, fail_count = 0, n_tests = 0, cyc = 0, xs = 0, hs = 0;

    channel_service_scheduler u_channel_service_scheduler (.i_ref_clk(clk), .i_rstn(rstn),
        .i_chan_req(req), .i_chan_prio(prio), .i_state_done(done), .i_exec_ram_req(eram),
        .i_host_ram_req(host), .o_grant(gnt), .o_exec_start(start), .o_slot_idx(sidx),
        .o_slot_level(slv), .o_nop_busy(nop), .o_xfer_busy(xfer), .o_service_request_latch(srl_o),
        .o_service_grant_latch(sgl_o), .o_ram_arb(arb));
    exec_unit_model u_exec_unit_model (.i_ref_clk(clk), .i_rstn(rstn), .i_exec_start(start),
        .i_exec_stall(arb.exec_stall), .o_state_done(done), .o_ram_req(eram));

    always #4 clk = ~clk;
    always @(posedge clk) host <= 1'($urandom);

    // ----------------
    // reference model
    // ----------------
    function automatic logic [1:0] slot_lvl(int s);
        return (s == 3) ? 2'h1 : (s % 2) ? 2'h2 : 2'h3;
    endfunction

    function automatic logic [15:0] elig(logic [1:0] l);
        for (int i = 0; i < 16; i++) elig[i] = service_request_latch[i] & ~service_grant_latch[i] & (prio[i] == l);
    endfunction

    // own level first, then the passing order of that slot kind
    function automatic int pick(output logic [1:0] lv);
        logic [1:0]  s;
        logic [5:0]  ord;
        logic [15:0] e;
        s = slot_lvl(slot);
        ord = (s == 2'h3) ? 6'h39 : (s == 2'h2) ? 6'h2D : 6'h1E;
        for (int k = 2; k >= 0; k--) begin
            lv = ord[2*k +: 2];
            e = elig(lv);
            for (int i = 0; i < 16; i++) if (e[i]) return i;
        end
        return -1;
    endfunction

    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic serve(logic [15:0] rereq, bit gap);
        int         c, n, cn, cx;
        logic [1:0] lv;
        bit         clr;
        c = pick(lv);
        for (n = 0; start !== 1'b1 && n < 50; n++) tick();
        check("start", 16'h1, 16'(start));
        if (gap) check("idle gap", 16'h1, 16'(n));
        check("chan", 16'(c), 16'(gnt.chan));
        check("level", 16'(lv), 16'(gnt.level));
        check("slot", 16'(slot), 16'(sidx));
        check("slot level", 16'(slot_lvl(slot)), 16'(slv));
        service_grant_latch[c] = 1'b1;
        service_request_latch[c] = 1'b0;
        check("req latch", service_request_latch, srl_o);
        check("grant latch", service_grant_latch, sgl_o);
        @(posedge clk);
        req <= rereq & (16'h1 << c);
        service_request_latch[c] = rereq[c];
        @(posedge clk);
        req <= 16'h0;
        #1;
        for (n = 0; gnt.valid === 1'b1 && n < 100; n++) tick();
        check("state end", 16'h0, 16'(gnt.valid));
        clr = (elig(lv) == 16'h0);
        for (int i = 0; i < 16; i++) if (clr && prio[i] == lv) service_grant_latch[i] = 1'b0;
        for (cn = 0; nop === 1'b1 && cn < 20; cn++) tick();
        for (cx = 0; xfer === 1'b1 && cx < 20; cx++) tick();
        check("no-op", clr ? 16'h4 : 16'h0, 16'(cn));
        check("transition", 16'hA, 16'(cx));
        slot = (slot + 1) % 7;
        check("next slot", 16'(slot), 16'(sidx));
    endtask

    task automatic run_case(logic [15:0][1:0] p, logic [15:0] mask, logic [15:0] rereq);
        int         k;
        logic [1:0] lv;
        @(posedge clk);
        prio <= p;
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        service_request_latch = mask;
        service_grant_latch = 16'h0;
        slot = 0;
        tick();
        check("reset latches", 16'h0, srl_o | sgl_o);
        check("reset outputs", 16'h0, {gnt.valid, start, sidx});
        @(posedge clk);
        req <= mask;
        @(posedge clk);
        req <= 16'h0;
        #1;
        for (k = 0; pick(lv) >= 0 && k < 12; k++) serve(rereq, k > 0);
        if (k < 12) begin
            repeat (20) tick();
            check("idle busy", 16'h0, {nop, xfer, gnt.valid});
            check("idle slot", 16'(slot), 16'(sidx));
        end
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // memory arbiter: one owner, neither party stalled over two clocks
    always @(negedge clk) begin
        xs = (rstn && arb.exec_stall === 1'b1) ? xs + 1 : 0;
        hs = (rstn && arb.host_stall === 1'b1) ? hs + 1 : 0;
        if (xs > 2 || hs > 2 || (rstn && (arb.exec_gnt & arb.host_gnt) !== 1'b0)) begin
            fail_count++;
            $display("CHECK FAILED ram stall expected 2 seen %0d", xs > hs ? xs : hs);
        end
    end

    // a hang is cut short well beyond the longest expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h7551));
        run_case(32'h000C_0C03, 16'h0221, 16'h0001);
        $display("test 0 done");
        run_case(32'h0000_4020, 16'h1084, 16'h0000);
        $display("test 1 done");
        for (int t = 2; t < 10; t++) begin
            run_case($urandom, 16'($urandom), 16'($urandom & $urandom));
            $display("test %0d done", t);
        end
        wrap_up();
    end
endmodule
